/* File: design/timer_map.vh */
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH
// ----------------------------------------
// Register byte addresses, per timer block
// ----------------------------------------
`define CTL_OFS        4'h0
`define COUNT_OFS      4'h4
`define RELOAD_OFS     4'h8
`define STAT_OFS       4'hc
`define TIMER1_BASE    5'h10
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_EN_BIT     7
`define CTL_POL_BIT    6
`define CTL_PRE_LSB    3
`define CTL_PRE_MSB    5
`define CTL_MODE_LSB   0
`define CTL_MODE_MSB   1
`define CTL_OUTEN_BIT  8
`define CTL_RESET      9'h000
`define MODE_ONESHOT   2'h0
`define MODE_CONT      2'h1
`define MODE_COUNTER   2'h2
// ----------------------------------------
// Reset and reload values
// ----------------------------------------
`define COUNT_RESET    16'h0000
`define RELOAD_RESET   16'h0000
`define COUNT_RESTART  16'h0001
`define PRE_RESET      7'h00
`endif

/* File: design/reload_timer_core.v */
`timescale 1ns/1ps
`include "timer_map.vh"
module reload_timer_core
(
	input  wire        ref_clk,
	input  wire        rst,
	input  wire [8:0]  ctl_wdata,
	input  wire        ctl_we,
	input  wire [15:0] count_wdata,
	input  wire        count_we,
	input  wire [15:0] reload_wdata,
	input  wire        reload_we,
	input  wire        timer_in,
	output reg  [8:0]  ctl_r,
	output reg  [15:0] count_r,
	output reg  [15:0] reload_r,
	output reg         timer_out,
	output reg         reload_pulse
);
	reg  [6:0] pre_cnt_r;
	reg        in_prev_r;
	reg        out_level_r;
	wire [1:0] mode    = ctl_r[`CTL_MODE_MSB:`CTL_MODE_LSB];
	wire [2:0] pre_sel = ctl_r[`CTL_PRE_MSB:`CTL_PRE_LSB];
	wire       pol     = ctl_r[`CTL_POL_BIT];
	wire       en      = ctl_r[`CTL_EN_BIT];
	wire       outen   = ctl_r[`CTL_OUTEN_BIT];
	wire [6:0] pre_max = (7'h01 << pre_sel) - 7'h01;
	wire       pre_tick = (pre_cnt_r == pre_max);
	wire       edge_in = pol ? (timer_in & ~in_prev_r) : (~timer_in & in_prev_r);
	wire       tick = en & ((mode == `MODE_COUNTER) ? edge_in : pre_tick);
	wire [15:0] inc = count_r + 16'h0001;
	wire       hit = tick & (count_r == reload_r);
	// ----------------------------------------
	// Prescaler, counter and reload
	// ----------------------------------------
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			ctl_r <= `CTL_RESET;
			count_r <= `COUNT_RESET;
			reload_r <= `RELOAD_RESET;
			pre_cnt_r <= `PRE_RESET;
			in_prev_r <= 1'b0;
			out_level_r <= 1'b0;
			timer_out <= 1'b0;
			reload_pulse <= 1'b0;
		end
		else
		begin
			in_prev_r <= timer_in;
			reload_pulse <= hit;
			if (!en || mode == `MODE_COUNTER || pre_tick)
				pre_cnt_r <= `PRE_RESET;
			else
				pre_cnt_r <= pre_cnt_r + 7'h01;
			if (ctl_we)
				ctl_r <= ctl_wdata;
			if (count_we)
				count_r <= count_wdata;
			else if (hit)
			begin
				count_r <= `COUNT_RESTART;
				if (mode == `MODE_ONESHOT)
					ctl_r[`CTL_EN_BIT] <= 1'b0;
			end
			else if (tick)
				count_r <= inc;
			if (reload_we)
				reload_r <= reload_wdata;
			// Software level load wins over a reload in the same cycle
			if (ctl_we && !ctl_wdata[`CTL_EN_BIT])
				out_level_r <= ctl_wdata[`CTL_POL_BIT];
			else if (hit && mode == `MODE_ONESHOT)
				out_level_r <= pol;
			else if (hit && outen)
				out_level_r <= ~out_level_r;
			if (hit && outen)
				timer_out <= ~out_level_r;
			else
				timer_out <= out_level_r;
		end
	end
endmodule

/* File: design/reloadable_timer_16bit.v */
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "timer_map.vh"
module reloadable_timer_16bit
(
	input  wire        ref_clk,
	input  wire        rst,
	input  wire [4:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output reg         waitrequest,
	input  wire [1:0]  timer_in,
	output reg  [1:0]  timer_out,
	output reg  [1:0]  reload_event
);
	reg         done_r;
	wire [8:0]  ctl_q    [0:1];
	wire [15:0] count_q  [0:1];
	wire [15:0] reload_q [0:1];
	wire [1:0]  out_w;
	wire [1:0]  ev_w;
	wire        sel = address[4];
	wire [3:0]  ofs = address[3:0];
	wire        acc = (read | write) & ~done_r;
	// Write lands at the edge that samples waitrequest low
	wire [1:0]  wr_sel = {sel, ~sel} & {2{write & ~waitrequest}};
	// ----------------------------------------
	// Timer instances
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : tmr
			wire hit_me = wr_sel[g];
			reload_timer_core u_core
			(
				.ref_clk      (ref_clk),
				.rst          (rst),
				.ctl_wdata    (writedata[8:0]),
				.ctl_we       (hit_me & (ofs == `CTL_OFS)),
				.count_wdata  (writedata[15:0]),
				.count_we     (hit_me & (ofs == `COUNT_OFS)),
				.reload_wdata (writedata[15:0]),
				.reload_we    (hit_me & (ofs == `RELOAD_OFS)),
				.timer_in     (timer_in[g]),
				.ctl_r        (ctl_q[g]),
				.count_r      (count_q[g]),
				.reload_r     (reload_q[g]),
				.timer_out    (out_w[g]),
				.reload_pulse (ev_w[g])
			);
		end
	endgenerate
	// ----------------------------------------
	// Avalon slave, one wait state
	// ----------------------------------------
	reg [31:0] rd_nxt;
	always @*
	begin
		rd_nxt = 32'h00000000;
		case (ofs)
			`CTL_OFS:    rd_nxt = {23'h000000, ctl_q[sel]};
			`COUNT_OFS:  rd_nxt = {16'h0000, count_q[sel]};
			`RELOAD_OFS: rd_nxt = {16'h0000, reload_q[sel]};
			`STAT_OFS:   rd_nxt = {31'h00000000, ctl_q[sel][`CTL_EN_BIT]};
			default:     rd_nxt = 32'h00000000;
		endcase
	end
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			done_r <= 1'b0;
			readdata <= 32'h00000000;
			waitrequest <= 1'b1;
			timer_out <= 2'h0;
			reload_event <= 2'h0;
		end
		else
		begin
			done_r <= acc;
			waitrequest <= ~acc;
			if (acc && read)
				readdata <= rd_nxt;
			timer_out <= out_w;
			reload_event <= ev_w;
		end
	end
endmodule

/* File: tb/timer_monitor.sv */
`timescale 1ns/1ps
module timer_monitor
(
	input logic        ref_clk,
	input logic        rst,
	input logic [4:0]  address,
	input logic        read,
	input logic        write,
	input logic [31:0] readdata,
	input logic        waitrequest,
	input logic [1:0]  timer_out,
	input logic [1:0]  reload_event
);
	logic [1:0] seen_r;
	always @(posedge ref_clk)
		if (rst)
			seen_r <= 2'h0;
		else if (write)
			seen_r[address[4]] <= 1'b1;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_ans; (read || write) && waitrequest && $past(waitrequest) |=> !waitrequest; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_one; !waitrequest |=> waitrequest; endproperty
	a_one: assert property (p_one) else $error("answer too long");
	property p_hi; read && !waitrequest |-> readdata[31:16] == 16'h0000; endproperty
	a_hi: assert property (p_hi) else $error("upper bits set");
	property p_hold; !read |=> $stable(readdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rst; disable iff (1'b0) rst |=> waitrequest && !reload_event && !timer_out; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_ev0; reload_event[0] |-> seen_r[0]; endproperty
	a_ev0: assert property (p_ev0) else $error("stray event 0");
	property p_ev1; reload_event[1] |-> seen_r[1]; endproperty
	a_ev1: assert property (p_ev1) else $error("stray event 1");
	property p_out1; timer_out[1] |-> seen_r[1]; endproperty
	a_out1: assert property (p_out1) else $error("stray output 1");
	c_ev0: cover property (reload_event[0]);
	c_ev1: cover property (reload_event[1]);
	c_rd: cover property (read && !waitrequest);
endmodule
bind reloadable_timer_16bit timer_monitor timer_monitor_i (.ref_clk(ref_clk), .rst(rst),
	.address(address), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .timer_out(timer_out), .reload_event(reload_event));

/* File: tb/edge_source.sv */
`timescale 1ns/1ps
module edge_source
(
	input  logic ref_clk,
	input  logic go,
	output logic pin
);
	logic [1:0] c_r = 2'h0;
	initial pin = 1'b0;
	always @(posedge ref_clk)
		if (go)
		begin
			c_r <= c_r + 2'h1;
			if (c_r == 2'h3)
				pin <= !pin;
		end
endmodule

/* File: tb/reloadable_timer_16bit_tb_top.sv */
`timescale 1ns/1ps
module reloadable_timer_16bit_tb_top;
	logic        ref_clk = 0, rst = 1, read = 0, write = 0, go = 0, waitrequest, pin;
	logic [4:0]  address = 5'h00;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic [1:0]  timer_out, reload_event;
	int          n, err_count = 0, compares = 0;
	logic [31:0] row_ctl [3] = '{32'h181, 32'h199, 32'h1b9};
	logic [31:0] row_rel [3] = '{32'h5, 32'h3, 32'h2};
	logic [31:0] row_exp [3] = '{32'h5, 32'h18, 32'h100};
	always #4 ref_clk = !ref_clk;
	reloadable_timer_16bit reloadable_timer_16bit_i (.ref_clk(ref_clk), .rst(rst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .timer_in({pin, pin}),
		.timer_out(timer_out), .reload_event(reload_event));
	edge_source edge_source_i (.ref_clk(ref_clk), .go(go), .pin(pin));
	task give_verdict;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{read, write, address, writedata} <= {!w, w, a, d};
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		rd = readdata;
		{read, write} <= 2'b00;
	endtask
	task cfg(input logic [4:0] b, input logic [31:0] ctl, cnt, rel);
		bus(1, b, ctl & 32'hffffff7f);
		bus(1, b | 5'h04, cnt);
		bus(1, b | 5'h08, rel);
		bus(1, b, ctl);
	endtask
	task wev(input int i);
		n = 0;
		do begin @(posedge ref_clk); n++; end while (reload_event[i] !== 1'b1);
	endtask
	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst <= 0;
		bus(0, 5'h00, 0);
		chk(rd, 0);
		bus(1, 5'h02, 32'hff);
		bus(0, 5'h02, 0);
		chk(rd, 0);
		$display("reset test done");
		for (int i = 0; i < 3; i++)
		begin
			cfg(5'h00, row_ctl[i], 1, row_rel[i]);
			wev(0);
			chk(timer_out[0], 1);
			wev(0);
			chk(n, row_exp[i]);
			chk(timer_out[0], 0);
		end
		$display("period rows done");
		cfg(5'h00, 32'h180, 3, 6);
		chk(timer_out[0], 0);
		wev(0);
		chk(timer_out[0], 1);
		@(posedge ref_clk);
		chk(timer_out[0], 0);
		@(posedge ref_clk);
		bus(0, 5'h0c, 0);
		chk(rd, 0);
		bus(0, 5'h04, 0);
		chk(rd, 1);
		cfg(5'h00, 32'h180, 3, 40);
		bus(1, 5'h00, 32'h1c0);
		chk(timer_out[0], 0);
		wev(0);
		@(posedge ref_clk);
		chk(timer_out[0], 1);
		$display("one-shot done");
		cfg(5'h00, 32'h81, 32'hfffe, 0);
		wev(0);
		wev(0);
		chk(n, 32'h10000);
		$display("wrap done");
		cfg(5'h10, 32'h1c2, 1, 3);
		chk(timer_out[1], 1);
		go <= 1;
		wev(1);
		chk(timer_out[1], 0);
		wev(1);
		chk(n, 24);
		chk(timer_out[1], 1);
		$display("counter done");
		rst <= 1;
		repeat (2) @(posedge ref_clk);
		rst <= 0;
		chk(timer_out, 0);
		bus(0, 5'h18, 0);
		chk(rd, 0);
		bus(0, 5'h14, 0);
		chk(rd, 0);
		$display("mid-run reset done");
		give_verdict;
	end
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		err_count++;
		give_verdict;
	end
endmodule
